// ---- bench/psl_led_driver_tb.sv ----
// self-checking bench for the status led driver
`timescale 1ns/1ns
module psl_led_driver_tb;
  import psl_pkg::*;
  localparam int MSC = 10;
  logic        clk = 1'b0, rstn = 1'b0, ce = 1'b1, runEnd;
  logic        awValid = 1'b0, wValid = 1'b0, arValid = 1'b0, bReady = 1'b1, rReady = 1'b1;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic        redView = 1'b0;
  logic [1:0]  linkUp = 2'h0, frameAct = 2'h0, bResp, rResp;
  logic [7:0]  awAddr = 8'h0, arAddr = 8'h0;
  logic [31:0] wData = 32'h0, rData;
  logic [15:0] onLen;
  logic [33:0] q[$];
  logic [15:0] qOn[$];
  psl_leds_s   leds;
  int          error_cnt, checks_done, timeoutCnt;
  logic [7:0]  sa[7] = '{OFF_TCP, OFF_TCP, OFF_TCP, OFF_CTRL, OFF_NODE, OFF_NODE, OFF_NODE};
  logic [3:0]  sv[7] = '{4'h3, 4'hB, 4'h0, 4'h1, 4'h5, 4'hD, 4'h7};
  logic [5:0]  se[7] = '{6'h14, 6'h24, 6'h04, 6'h04, 6'h14, 6'h34, 6'h04};
  logic [7:0]  da[9] = '{OFF_NODE, OFF_NODE, OFF_NODE, OFF_NODE, OFF_NODE, OFF_CTRL, OFF_TCP, OFF_TCP, OFF_TCP};
  logic [3:0]  dv[9] = '{4'h2, 4'h6, 4'h1, 4'h3, 4'h4, 4'h0, 4'h1, 4'h2, 4'h4};
  int          dl[9] = '{FLASH_MS*MSC, BLINK_MS*MSC, FLICK_MS*MSC, FLASH_MS*MSC, FLASH_MS*MSC, 0,
                         HZ1_HALF_MS*MSC, HZ5_HALF_MS*MSC, HZ2_ON_MS*MSC};

  always #5 clk = ~clk;

  psl_led_driver #(.MS_CYCLES(MSC)) i_dut (
    .clk(clk), .rstn(rstn), .ce(ce), .linkUp(linkUp), .frameAct(frameAct),
    .s_axi_awaddr(awAddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
    .s_axi_araddr(arAddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
    .s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .leds(leds));
  psl_led_viewer i_view (.clk(clk), .rstn(rstn), .lit(redView ? leds.comRed : leds.comGreen), .runEnd(runEnd),
                         .onLen(onLen));

  // ----
  // result monitor
  // ----
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] e, input logic [33:0] g);
    checks_done++;
    if (e !== g) begin
      error_cnt++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  always @(posedge clk) begin
    if (rValid === 1'b1 && rReady === 1'b1) cmp(q.pop_front(), {rResp, rData});
    if (bValid === 1'b1 && bReady === 1'b1) cmp(q.pop_front(), {bResp, 32'h0});
    if (runEnd === 1'b1 && qOn.size() > 0) cmp({18'h0, qOn.pop_front()}, {18'h0, onLen});
    timeoutCnt++;
    if (timeoutCnt == 80000) begin
      error_cnt++;
      summarize();
    end
  end

  // ----
  // bus and indicator tasks
  // ----
  task automatic wr(input logic [7:0] a, input logic [3:0] v, input logic [1:0] r);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    q.push_back({r, 32'h0});
    awAddr <= a;
    wData <= ($urandom() << 4) | {28'h0, v};
    awValid <= 1'b1;
    wValid <= 1'b1;
    while (!(ad && wd)) begin
      @(negedge clk);
      if (awReady === 1'b1) ad = 1'b1;
      if (wReady === 1'b1) wd = 1'b1;
      @(posedge clk);
      if (ad) awValid <= 1'b0;
      if (wd) wValid <= 1'b0;
    end
    do @(negedge clk); while (bValid !== 1'b1);
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    q.push_back(e);
    arAddr <= a;
    arValid <= 1'b1;
    do @(negedge clk); while (arReady !== 1'b1);
    @(posedge clk);
    arValid <= 1'b0;
    do @(negedge clk); while (rValid !== 1'b1);
    @(posedge clk);
  endtask
  task automatic run(input logic [15:0] n);
    do @(posedge clk); while (runEnd !== 1'b1);
    @(negedge clk);
    qOn.push_back(n);
    do @(posedge clk); while (runEnd !== 1'b1);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(93678));
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd(OFF_CTRL, {RESP_OKAY, 32'h0});
    rd(OFF_TCP, {RESP_OKAY, 32'h0});
    rd(OFF_NODE, {RESP_OKAY, 32'h0});
    rd(OFF_LED, {RESP_OKAY, 32'h0});
    rd(8'h10, {RESP_SLVERR, 32'h0});
    wr(OFF_LED, 4'hF, RESP_SLVERR);
    rd(OFF_LED, {RESP_OKAY, 32'h0});
    $display("test reset done");
    linkUp <= 2'b01;
    for (int i = 0; i < 7; i++) begin
      wr(sa[i], sv[i], RESP_OKAY);
      rd(OFF_LED, {RESP_OKAY, 26'h0, se[i]});
    end
    $display("test steady done");
    ce <= 1'b0;
    linkUp <= 2'b10;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    linkUp <= 2'b01;
    rd(OFF_LED, {RESP_OKAY, 26'h0, 6'h04});
    $display("test freeze done");
    for (int i = 0; i < 9; i++) begin
      frameAct <= 2'($urandom());
      linkUp <= 2'($urandom());
      redView <= (i == 8);
      wr(da[i], dv[i], RESP_OKAY);
      if (dl[i] != 0) run(16'(dl[i]));
    end
    $display("test timing done");
    summarize();
  end
endmodule

// ---- bench/psl_led_properties.sv ----
// concurrent checks on the status led driver ports
`timescale 1ns/1ns
module psl_led_properties (
  input wire logic               clk,
  input wire logic               rstn,
  input wire logic               ce,
  input wire logic [1:0]         linkUp,
  input wire logic [1:0]         frameAct,
  input wire logic               s_axi_awvalid,
  input wire logic               s_axi_awready,
  input wire logic               s_axi_wvalid,
  input wire logic               s_axi_wready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire logic [31:0]        s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire psl_pkg::psl_leds_s leds
);
  import psl_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----
  // bus and indicator checks
  // ----
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  aw_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  w_refuse_a: assert property (s_axi_bvalid |-> !s_axi_wready)
    else $error("data taken during response");
  ar_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during read data");
  rd_latency_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  wr_latency_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  link_off_a: assert property ((ce && !linkUp[1]) [*2] |=> !leds.link[1])
    else $error("link lit without link");
  act_off_a: assert property ((ce && !frameAct[1]) [*2] |=> !leds.activity[1])
    else $error("activity lit without frames");
  link_on_a: assert property ((ce && linkUp[0] && !frameAct[0]) [*2] |=> leds.link[0])
    else $error("link dark with link present");
  ce_freeze_a: assert property (!ce |=> $stable(leds) && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
    else $error("state moved while clock enable low");
endmodule
bind psl_led_driver psl_led_properties i_props (
  .clk(clk), .rstn(rstn), .ce(ce), .linkUp(linkUp), .frameAct(frameAct),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .leds(leds));

// ---- bench/psl_led_viewer.sv ----
// operator view of one indicator, measuring each lit run
`timescale 1ns/1ns
module psl_led_viewer (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   lit,
  output logic        runEnd,
  output logic [15:0] onLen
);
  logic [15:0] cnt;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 16'h0;
      runEnd <= 1'b0;
      onLen <= 16'h0;
    end else begin
      runEnd <= !lit && cnt != 16'h0;
      if (!lit && cnt != 16'h0) onLen <= cnt;
      cnt <= lit ? cnt + 16'h1 : 16'h0;
    end
  end
endmodule

// ---- verilog/psl_led_driver.sv ----
// status led driver top with axi4-lite register access
//
// The implementer's own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module psl_led_driver #(
  parameter int MS_CYCLES = psl_pkg::MS_CYC,
  parameter int ADDR_W    = 8
) (
  input  wire logic              clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic [1:0]        linkUp,
  input  wire logic [1:0]        frameAct,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output psl_pkg::psl_leds_s     leds
);
  import psl_pkg::*;

  localparam int TICK_W = $clog2(MS_CYCLES + 1);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [REG_W-1:0]  ctrlReg;
  logic [REG_W-1:0]  tcpReg;
  logic [REG_W-1:0]  nodeReg;
  logic [TICK_W-1:0] tickCnt;
  logic              msTick;
  logic              awHeld;
  logic              wHeld;
  logic [ADDR_W-1:0] awAddr;
  logic [31:0]       wData;
  logic [3:0]        wStrb;
  logic              comLit;
  logic              actLit;
  psl_pat_e          comPat;
  psl_pat_e          greenPat;
  psl_pat_e          redPat;
  psl_pat_e          nodePat;
  psl_leds_s         next_leds;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [REG_W-1:0] applyStrb(input logic [REG_W-1:0] old,
                                                  input logic [31:0] d,
                                                  input logic [3:0] s);
    applyStrb = s[0] ? d[REG_W-1:0] : old;
  endfunction

  function automatic logic isReg(input logic [ADDR_W-1:0] a);
    isReg = (a[7:0] == OFF_CTRL) || (a[7:0] == OFF_TCP) ||
            (a[7:0] == OFF_NODE) || (a[7:0] == OFF_LED);
  endfunction

  // ----------------------------------------------------------------
  // millisecond timebase
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tickCnt <= '0;
      msTick  <= 1'b0;
    end else if (ce) begin
      msTick  <= (tickCnt == TICK_W'(MS_CYCLES - 1));
      tickCnt <= (tickCnt == TICK_W'(MS_CYCLES - 1)) ? '0 : tickCnt + TICK_W'(1);
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite write channel
  // ----------------------------------------------------------------
  wire awTake  = s_axi_awvalid && s_axi_awready;
  wire wTake   = s_axi_wvalid && s_axi_wready;
  wire doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire wrHit   = isReg(awAddr);
  wire wrRO    = (awAddr[7:0] == OFF_LED);

  assign s_axi_awready = ce && !awHeld && !s_axi_bvalid;
  assign s_axi_wready  = ce && !wHeld && !s_axi_bvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      awHeld       <= 1'b0;
      wHeld        <= 1'b0;
      awAddr       <= '0;
      wData        <= '0;
      wStrb        <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (ce) begin
      if (awTake) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      if (wTake) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wrHit && !wrRO) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrlReg <= CTRL_RST;
      tcpReg  <= TCP_RST;
      nodeReg <= NODE_RST;
    end else if (ce && doWrite) begin
      if (awAddr[7:0] == OFF_CTRL) begin
        ctrlReg <= applyStrb(ctrlReg, wData, wStrb);
      end
      if (awAddr[7:0] == OFF_TCP) begin
        tcpReg <= applyStrb(tcpReg, wData, wStrb);
      end
      if (awAddr[7:0] == OFF_NODE) begin
        nodeReg <= applyStrb(nodeReg, wData, wStrb);
      end
    end
  end

  // ----------------------------------------------------------------
  // axi4-lite read channel
  // ----------------------------------------------------------------
  wire [ADDR_W-1:0] rdA = s_axi_araddr;
  wire [31:0] rdMux =
    (rdA[7:0] == OFF_CTRL) ? {28'h0000000, ctrlReg} :
    (rdA[7:0] == OFF_TCP)  ? {28'h0000000, tcpReg} :
    (rdA[7:0] == OFF_NODE) ? {28'h0000000, nodeReg} :
    (rdA[7:0] == OFF_LED)  ? {26'h0, leds} : 32'h00000000;

  assign s_axi_arready = ce && !s_axi_rvalid;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rdMux;
        s_axi_rresp  <= isReg(rdA) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // status decode
  // ----------------------------------------------------------------
  wire       nodeMode = ctrlReg[CTRL_PERS_BIT];
  wire [1:0] tcpState = tcpReg[TCP_STATE_LSB +: 2];
  wire       sysErr   = tcpReg[TCP_SYSERR_BIT];
  wire       comErr   = tcpReg[TCP_COMERR_BIT];
  wire [2:0] nodeSt   = nodeReg[NODE_STATE_LSB +: 3];
  wire       nodeErr  = nodeReg[NODE_ERR_BIT];
  wire       redOwns  = sysErr || comErr;
  wire       altPat   = (comPat == PAT_BLINK) || (comPat == PAT_FLICKER);

  always_comb begin
    unique case (psl_tcp_e'(tcpState))
      TCP_NOT_READY:    greenPat = PAT_OFF;
      TCP_UNCONFIGURED: greenPat = PAT_HZ1;
      TCP_WAITING:      greenPat = PAT_HZ5;
      TCP_CONNECTED:    greenPat = PAT_ON;
    endcase
  end

  assign redPat = sysErr ? PAT_HZ2Q : PAT_ON;

  always_comb begin
    unique case (psl_node_e'(nodeSt))
      NODE_INIT:        nodePat = PAT_OFF;
      NODE_BASIC_ETH:   nodePat = PAT_FLICKER;
      NODE_PREOP1:      nodePat = PAT_SINGLE;
      NODE_PREOP2:      nodePat = PAT_DOUBLE;
      NODE_READY:       nodePat = PAT_TRIPLE;
      NODE_OPERATIONAL: nodePat = PAT_ON;
      NODE_STOPPED:     nodePat = PAT_BLINK;
      NODE_UNUSED:      nodePat = PAT_OFF;
    endcase
  end

  assign comPat = nodeMode ? nodePat : (redOwns ? redPat : greenPat);

  // ----------------------------------------------------------------
  // waveform generators
  // ----------------------------------------------------------------
  psl_pattern uComPattern (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (ce),
    .msTick (msTick),
    .pat    (comPat),
    .lit    (comLit)
  );

  psl_pattern uActPattern (
    .clk    (clk),
    .rstn   (rstn),
    .ce     (ce),
    .msTick (msTick),
    .pat    (PAT_FLICKER),
    .lit    (actLit)
  );

  // ----------------------------------------------------------------
  // led mapping
  // ----------------------------------------------------------------
  always_comb begin
    if (nodeMode) begin
      next_leds.comGreen = comLit;
      next_leds.comRed   = nodeErr || (altPat && !comLit);
      for (int c = 0; c < 2; c++) begin
        next_leds.link[c] = linkUp[c] && (!frameAct[c] || actLit);
      end
      next_leds.activity = 2'b00;
    end else begin
      next_leds.comGreen = !redOwns && comLit;
      next_leds.comRed   = redOwns && comLit;
      next_leds.link     = linkUp;
      next_leds.activity = frameAct & {2{actLit}};
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      leds <= '0;
    end else if (ce) begin
      leds <= next_leds;
    end
  end

endmodule

// ---- verilog/psl_pattern.sv ----
// millisecond-stepped indicator waveform generator
`timescale 1ns/1ns
module psl_pattern (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic             ce,
  input  wire logic             msTick,
  input  wire psl_pkg::psl_pat_e pat,
  output logic                  lit
);
  import psl_pkg::*;

  logic [PAT_CNT_W-1:0] msCnt;
  psl_pat_e             lastPat;

  // ----------------------------------------------------------------
  // waveform tables
  // ----------------------------------------------------------------
  function automatic logic [PAT_CNT_W-1:0] periodMs(input psl_pat_e p);
    unique case (p)
      PAT_BLINK:   periodMs = PAT_CNT_W'(2 * BLINK_MS);
      PAT_FLICKER: periodMs = PAT_CNT_W'(2 * FLICK_MS);
      PAT_SINGLE:  periodMs = PAT_CNT_W'(FLASH_MS + GAP_MS);
      PAT_DOUBLE:  periodMs = PAT_CNT_W'(3 * FLASH_MS + GAP_MS);
      PAT_TRIPLE:  periodMs = PAT_CNT_W'(5 * FLASH_MS + GAP_MS);
      PAT_HZ1:     periodMs = PAT_CNT_W'(2 * HZ1_HALF_MS);
      PAT_HZ5:     periodMs = PAT_CNT_W'(2 * HZ5_HALF_MS);
      PAT_HZ2Q:    periodMs = PAT_CNT_W'(HZ2_PER_MS);
      default:     periodMs = PAT_CNT_W'(1);
    endcase
  endfunction

  function automatic logic flashLit(input logic [PAT_CNT_W-1:0] t, input int n);
    flashLit = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (t >= PAT_CNT_W'(2 * i * FLASH_MS) && t < PAT_CNT_W'((2 * i + 1) * FLASH_MS)) begin
        flashLit = 1'b1;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // phase counter, restarts when the pattern changes
  // ----------------------------------------------------------------
  wire patChanged = (pat != lastPat);
  wire lastMs     = (msCnt >= periodMs(pat) - PAT_CNT_W'(1));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      msCnt   <= '0;
      lastPat <= PAT_OFF;
    end else if (ce) begin
      lastPat <= pat;
      if (patChanged) begin
        msCnt <= '0;
      end else if (msTick) begin
        msCnt <= lastMs ? '0 : msCnt + PAT_CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // on/off decode
  // ----------------------------------------------------------------
  always_comb begin
    unique case (pat)
      PAT_OFF:     lit = 1'b0;
      PAT_ON:      lit = 1'b1;
      PAT_BLINK:   lit = (msCnt < PAT_CNT_W'(BLINK_MS));
      PAT_FLICKER: lit = (msCnt < PAT_CNT_W'(FLICK_MS));
      PAT_SINGLE:  lit = flashLit(msCnt, 1);
      PAT_DOUBLE:  lit = flashLit(msCnt, 2);
      PAT_TRIPLE:  lit = flashLit(msCnt, 3);
      PAT_HZ1:     lit = (msCnt < PAT_CNT_W'(HZ1_HALF_MS));
      PAT_HZ5:     lit = (msCnt < PAT_CNT_W'(HZ5_HALF_MS));
      PAT_HZ2Q:    lit = (msCnt < PAT_CNT_W'(HZ2_ON_MS));
      default:     lit = 1'b0;
    endcase
  end

endmodule

// ---- verilog/psl_pkg.sv ----
// constants, types and register map of the protocol status led driver
package psl_pkg;

  // ----------------------------------------------------------------
  // timebase
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int MS_NS  = 1000000;
  localparam int MS_CYC = MS_NS / CLK_NS;

  localparam int BLINK_MS   = 200;
  localparam int FLICK_MS   = 50;
  localparam int FLASH_MS   = 200;
  localparam int GAP_MS     = 1000;
  localparam int HZ1_HALF_MS = 500;
  localparam int HZ5_HALF_MS = 100;
  localparam int HZ2_PER_MS = 500;
  localparam int HZ2_ON_MS  = 125;
  localparam int PAT_CNT_W  = 11;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TCP  = 8'h04;
  localparam logic [7:0] OFF_NODE = 8'h08;
  localparam logic [7:0] OFF_LED  = 8'h0C;

  localparam int CTRL_PERS_BIT  = 0;
  localparam int TCP_STATE_LSB  = 0;
  localparam int TCP_SYSERR_BIT = 2;
  localparam int TCP_COMERR_BIT = 3;
  localparam int NODE_STATE_LSB = 0;
  localparam int NODE_ERR_BIT   = 3;
  localparam int REG_W          = 4;

  localparam logic [REG_W-1:0] CTRL_RST = 4'h0;
  localparam logic [REG_W-1:0] TCP_RST  = 4'h0;
  localparam logic [REG_W-1:0] NODE_RST = 4'h0;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    PAT_OFF, PAT_ON, PAT_BLINK, PAT_FLICKER, PAT_SINGLE,
    PAT_DOUBLE, PAT_TRIPLE, PAT_HZ1, PAT_HZ5, PAT_HZ2Q
  } psl_pat_e;

  typedef enum logic [1:0] {
    TCP_NOT_READY, TCP_UNCONFIGURED, TCP_WAITING, TCP_CONNECTED
  } psl_tcp_e;

  typedef enum logic [2:0] {
    NODE_INIT, NODE_BASIC_ETH, NODE_PREOP1, NODE_PREOP2,
    NODE_READY, NODE_OPERATIONAL, NODE_STOPPED, NODE_UNUSED
  } psl_node_e;

  typedef struct packed {
    logic       comRed;
    logic       comGreen;
    logic [1:0] link;
    logic [1:0] activity;
  } psl_leds_s;

endpackage
